/* verilog/adsw_defines.svh */
// Constants for the antenna diversity switch: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the design files.
`ifndef ADSW_DEFINES_SVH
`define ADSW_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADSW_OFF_CTRL      8'h00
`define ADSW_OFF_THRESH    8'h04
`define ADSW_OFF_STATUS    8'h08
`define ADSW_OFF_CMD       8'h0c

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define ADSW_CTRL_TX_EN    0
`define ADSW_CTRL_RX_EN    1
`define ADSW_CTRL_OUT_EN   2
`define ADSW_CTRL_ALT_PINS 3
`define ADSW_CTRL_RESET    4'h0

// ----------------------------------------------------------------
// Threshold fields
// ----------------------------------------------------------------
`define ADSW_THR_ED_LSB    0
`define ADSW_THR_SQ_LSB    8
`define ADSW_THR_RESET     16'h0000

// ----------------------------------------------------------------
// Status fields and command bit
// ----------------------------------------------------------------
`define ADSW_STAT_CUR      0
`define ADSW_STAT_LAST_TX  1
`define ADSW_STAT_LAST_RX  2
`define ADSW_CMD_TOGGLE    0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ADSW_CLK_HZ        25000000
`define ADSW_ED_PERIOD_NS  40000
`define ADSW_ED_CYCLES     ((`ADSW_ED_PERIOD_NS * (`ADSW_CLK_HZ / 1000000)) / 1000)

`endif

/* verilog/adsw_pkg.sv */
// Types shared by the antenna diversity switch modules.
// Uses nothing from the defines header.
package adsw_pkg;
	typedef enum logic [1:0] {
		ADSW_IDLE     = 2'b00,
		ADSW_TX       = 2'b01,
		ADSW_WAIT_ACK = 2'b10
	} adsw_txst_e;
endpackage

/* verilog/adsw_rx_if.sv */
// Interface carrying receive-decision signals between top and decider.
// Assumes a single clock domain.
`timescale 1ns/10ps
interface adsw_rx_if;
	logic       rx_enable;
	logic [7:0] energy_thresh;
	logic [7:0] quality_thresh;
	logic       blocked;
	logic       switch_req;
	modport top (output rx_enable, output energy_thresh, output quality_thresh,
		output blocked, input switch_req);
	modport dec (input rx_enable, input energy_thresh, input quality_thresh,
		input blocked, output switch_req);
endinterface

/* verilog/adsw_interval.sv */
// Free-running interval tick every 40 us.
// Assumes ref_clk at the rate in the defines header.
`timescale 1ns/10ps
`include "adsw_defines.svh"
module adsw_interval (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic nrst,
	// Tick out
	output logic      tick
);
	localparam int unsigned CYC = `ADSW_ED_CYCLES;
	logic [9:0] cnt;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cnt  <= 10'h000;
			tick <= 1'b0;
		end else if (cnt == 10'(CYC - 1)) begin
			cnt  <= 10'h000;
			tick <= 1'b1;
		end else begin
			cnt  <= cnt + 10'h001;
			tick <= 1'b0;
		end
	end
endmodule

/* verilog/adsw_rx_decide.sv */
// Receive switch decision: energy sampled each interval against threshold.
// Assumes energy and quality inputs are synchronous to ref_clk.
`timescale 1ns/10ps
`include "adsw_defines.svh"
module adsw_rx_decide (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic nrst,
	// Interval tick and radio measurements
	input  wire logic       tick,
	input  wire logic [7:0] energy,
	input  wire logic       preamble_det,
	input  wire logic [7:0] preamble_quality,
	// Link to top
	adsw_rx_if.dec          rx
);
	logic good_preamble;

	// Good preamble seen since the last sample blocks the next one
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			good_preamble <= 1'b0;
		end else if (preamble_det && preamble_quality > rx.quality_thresh) begin
			good_preamble <= 1'b1;
		end else if (tick) begin
			good_preamble <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rx.switch_req <= 1'b0;
		end else begin
			rx.switch_req <= tick && rx.rx_enable && (energy < rx.energy_thresh)
				&& !rx.blocked && !good_preamble;
		end
	end
endmodule

/* verilog/adsw_top.sv */
// Antenna diversity switch: drives the complementary select pair.
// Assumes a MAC that reports transmit start/end, ack and retry events,
// and a radio that reports energy, preamble quality and packet reception.
`timescale 1ns/10ps
`include "adsw_defines.svh"
module adsw_top (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	// Register port
	input  wire logic [7:0] addr,
	input  wire logic [31:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic [31:0]     rdata,
	// MAC events
	input  wire logic       tx_start,
	input  wire logic       tx_done,
	input  wire logic       ack_received,
	input  wire logic       ack_timeout,
	input  wire logic       retry_start,
	// Radio measurements
	input  wire logic       rx_busy,
	input  wire logic       rx_packet_done,
	input  wire logic [7:0] energy,
	input  wire logic       preamble_det,
	input  wire logic [7:0] preamble_quality,
	// Receive request to transceiver
	output logic            rx_mode,
	// Select pins
	output logic            antenna_select_pin_a,
	output logic            antenna_select_pin_b,
	output logic            antenna_select_pin_a_oe_n,
	output logic            antenna_select_pin_b_oe_n,
	output logic            alt_antenna_select_pin_a,
	output logic            alt_antenna_select_pin_b,
	output logic            alt_antenna_select_pin_a_oe_n,
	output logic            alt_antenna_select_pin_b_oe_n
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [3:0]  ctrl;
	logic [15:0] thresh;
	logic        cur_ant;
	logic        last_tx_ant;
	logic        last_rx_ant;
	logic        manual_toggle;
	logic        tick;
	adsw_pkg::adsw_txst_e txst;
	adsw_pkg::adsw_txst_e next_txst;
	adsw_rx_if   rx ();

	wire tx_en  = ctrl[`ADSW_CTRL_TX_EN];
	wire out_en = ctrl[`ADSW_CTRL_OUT_EN];
	wire alt    = ctrl[`ADSW_CTRL_ALT_PINS];
	wire wr_ctrl = wr && addr == `ADSW_OFF_CTRL;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= `ADSW_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= wdata[3:0];
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			thresh <= `ADSW_THR_RESET;
		end else if (wr && addr == `ADSW_OFF_THRESH) begin
			thresh <= wdata[15:0];
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			manual_toggle <= 1'b0;
		end else begin
			manual_toggle <= wr && addr == `ADSW_OFF_CMD && wdata[`ADSW_CMD_TOGGLE];
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= 32'h0000_0000;
		end else if (rd) begin
			case (addr)
				`ADSW_OFF_CTRL: begin
					rdata <= {28'h000_0000, ctrl};
				end
				`ADSW_OFF_THRESH: begin
					rdata <= {16'h0000, thresh};
				end
				`ADSW_OFF_STATUS: begin
					rdata <= {29'h0000_0000, last_rx_ant, last_tx_ant, cur_ant};
				end
				default: begin
					rdata <= 32'h0000_0000;
				end
			endcase
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Transmit sequence
	// ----------------------------------------------------------------
	always_comb begin
		next_txst = txst;
		case (txst)
			adsw_pkg::ADSW_IDLE: begin
				if (tx_start || retry_start) begin
					next_txst = adsw_pkg::ADSW_TX;
				end
			end
			adsw_pkg::ADSW_TX: begin
				if (tx_done) begin
					next_txst = adsw_pkg::ADSW_WAIT_ACK;
				end
			end
			adsw_pkg::ADSW_WAIT_ACK: begin
				if (ack_received || ack_timeout) begin
					next_txst = adsw_pkg::ADSW_IDLE;
				end
			end
			default: begin
				next_txst = adsw_pkg::ADSW_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			txst    <= adsw_pkg::ADSW_IDLE;
			rx_mode <= 1'b0;
		end else begin
			txst    <= next_txst;
			rx_mode <= next_txst == adsw_pkg::ADSW_WAIT_ACK;
		end
	end

	// ----------------------------------------------------------------
	// Antenna selection
	// ----------------------------------------------------------------
	assign rx.rx_enable      = ctrl[`ADSW_CTRL_RX_EN];
	assign rx.energy_thresh  = thresh[`ADSW_THR_ED_LSB +: 8];
	assign rx.quality_thresh = thresh[`ADSW_THR_SQ_LSB +: 8];
	assign rx.blocked        = rx_busy || txst != adsw_pkg::ADSW_IDLE;

	adsw_interval u_interval (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.tick    (tick)
	);

	adsw_rx_decide u_rx (
		.ref_clk          (ref_clk),
		.nrst             (nrst),
		.tick             (tick),
		.energy           (energy),
		.preamble_det     (preamble_det),
		.preamble_quality (preamble_quality),
		.rx               (rx)
	);

	// Toggle sources are XOR-combined so two at once cancel, not drop
	wire tx_toggle = tx_en && retry_start && txst == adsw_pkg::ADSW_IDLE;
	wire flips = tx_toggle ^ rx.switch_req ^ manual_toggle;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cur_ant <= 1'b0;
		end else if (flips) begin
			cur_ant <= ~cur_ant;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			last_tx_ant <= 1'b0;
			last_rx_ant <= 1'b0;
		end else begin
			if (txst == adsw_pkg::ADSW_TX && tx_done) begin
				last_tx_ant <= cur_ant;
			end
			if (rx_packet_done) begin
				last_rx_ant <= cur_ant;
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			antenna_select_pin_a          <= 1'b1;
			antenna_select_pin_b          <= 1'b0;
			antenna_select_pin_a_oe_n     <= 1'b1;
			antenna_select_pin_b_oe_n     <= 1'b1;
			alt_antenna_select_pin_a      <= 1'b1;
			alt_antenna_select_pin_b      <= 1'b0;
			alt_antenna_select_pin_a_oe_n <= 1'b1;
			alt_antenna_select_pin_b_oe_n <= 1'b1;
		end else begin
			antenna_select_pin_a          <= ~cur_ant;
			antenna_select_pin_b          <= cur_ant;
			alt_antenna_select_pin_a      <= ~cur_ant;
			alt_antenna_select_pin_b      <= cur_ant;
			antenna_select_pin_a_oe_n     <= ~(out_en && !alt);
			antenna_select_pin_b_oe_n     <= ~(out_en && !alt);
			alt_antenna_select_pin_a_oe_n <= ~(out_en && alt);
			alt_antenna_select_pin_b_oe_n <= ~(out_en && alt);
		end
	end
endmodule

/* test/adsw_rf_switch.sv */
// Model of the external two-way antenna switch on one select pair.
// Assumes the pair and its active-low enables come from the top.
`timescale 1ns/10ps
module adsw_rf_switch (
	// Select pair and enables
	input  wire logic [1:0] sel,
	input  wire logic [1:0] sel_oe_n,
	// Antenna on the radio port, one-hot, or zero when the switch is open
	output logic      [1:0] ant
);
	// Released pins see the pull-down, leaving the switch open
	logic [1:0] lvl;
	assign lvl = sel & ~sel_oe_n;
	assign ant = (lvl == 2'b10) ? 2'b01 : (lvl == 2'b01) ? 2'b10 : 2'b00;
endmodule

/* test/adsw_top_sva.sv */
// Port assertions for the antenna diversity switch.
// Assumes one clock domain, ref_clk, with async active-low nrst.
`timescale 1ns/10ps
module adsw_top_sva (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        nrst,
	// Watched ports
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic        tx_done,
	input wire logic        ack_received,
	input wire logic        ack_timeout,
	input wire logic        rx_mode,
	input wire logic        antenna_select_pin_a,
	input wire logic        antenna_select_pin_b,
	input wire logic        antenna_select_pin_a_oe_n,
	input wire logic        antenna_select_pin_b_oe_n,
	input wire logic        alt_antenna_select_pin_a,
	input wire logic        alt_antenna_select_pin_a_oe_n
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// Long ack wait with no software write: nothing may move the antenna
	sequence s_quiet_wait;
		(rx_mode && !wr)[*5];
	endsequence
	a_pins_complement: assert property (
		antenna_select_pin_a != antenna_select_pin_b) else $error("pair not complementary");
	a_alt_mirror: assert property (
		alt_antenna_select_pin_a == antenna_select_pin_a) else $error("alt pair differs");
	a_one_pair: assert property (
		antenna_select_pin_a_oe_n || alt_antenna_select_pin_a_oe_n) else $error("both pairs on");
	a_oe_pair: assert property (
		antenna_select_pin_a_oe_n == antenna_select_pin_b_oe_n) else $error("oe split");
	a_ack_rise: assert property (
		$rose(rx_mode) |-> $past(tx_done)) else $error("rx_mode without tx_done");
	a_ack_hold: assert property (
		rx_mode && !ack_received && !ack_timeout |=> rx_mode) else $error("rx_mode dropped");
	a_hold_await_ack: assert property (
		s_quiet_wait |-> $stable(antenna_select_pin_a)) else $error("switch in ack wait");
	a_rdata_idle: assert property (
		!rd |=> rdata == 32'h0) else $error("rdata without read");
	a_reset_idle: assert property (
		$rose(nrst) |-> antenna_select_pin_a && !antenna_select_pin_b
		&& antenna_select_pin_a_oe_n && alt_antenna_select_pin_a_oe_n) else $error("bad reset");
endmodule
bind adsw_top adsw_top_sva u_sva (.*);

/* test/tb_adsw_top.sv */
// Self-checking bench for the antenna diversity switch.
// Assumes design files, switch model and checker are compiled first.
`timescale 1ns/10ps
module tb_adsw_top;
	localparam int W = 2100;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  addr, energy, preamble_quality, e_thr, q_thr;
	logic [31:0] wdata, rdata;
	logic [6:0]  ev;
	logic        wr, rd, rx_busy, rx_mode, cur, lt, p;
	logic        antenna_select_pin_a, antenna_select_pin_b;
	logic        antenna_select_pin_a_oe_n, antenna_select_pin_b_oe_n;
	logic        alt_antenna_select_pin_a, alt_antenna_select_pin_b;
	logic        alt_antenna_select_pin_a_oe_n, alt_antenna_select_pin_b_oe_n;
	logic [1:0]  ant_def, ant_alt;
	int          n_fail = 0, n_compared = 0, seed = 27497, n;

	always #20 ref_clk = ~ref_clk;

	// MAC and radio events: start, done, ack, timeout, retry, rx done, preamble
	adsw_top uut (.tx_start(ev[0]), .tx_done(ev[1]), .ack_received(ev[2]),
		.ack_timeout(ev[3]), .retry_start(ev[4]), .rx_packet_done(ev[5]),
		.preamble_det(ev[6]), .*);
	adsw_rf_switch sw_def (.sel({antenna_select_pin_a, antenna_select_pin_b}),
		.sel_oe_n({antenna_select_pin_a_oe_n, antenna_select_pin_b_oe_n}), .ant(ant_def));
	adsw_rf_switch sw_alt (.sel({alt_antenna_select_pin_a, alt_antenna_select_pin_b}),
		.sel_oe_n({alt_antenna_select_pin_a_oe_n, alt_antenna_select_pin_b_oe_n}), .ant(ant_alt));

	function automatic logic [1:0] exp_ant(input logic on, input logic c);
		return on ? (c ? 2'b10 : 2'b01) : 2'b00;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 chk(rdata, exp, "rdata");
		@(posedge ref_clk);
	endtask
	task automatic pulse(input int k);
		ev[k] <= 1'b1;
		@(posedge ref_clk);
		ev[k] <= 1'b0;
		@(posedge ref_clk);
	endtask
	// Cycles until the select pair moves, W if it never does
	task automatic wait_flip(output int m);
		logic p0;
		p0 = antenna_select_pin_a;
		// Look 1 ns past each edge so the pin launched there has settled
		for (m = 0; m < W && antenna_select_pin_a === p0; m++) begin
			@(posedge ref_clk);
			#1;
		end
	endtask
	task automatic tally_and_finish;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#(40 * 30000);
		n_fail++;
		tally_and_finish;
	end

	initial begin
		{wr, rd, ev, rx_busy, addr, wdata, energy, preamble_quality} = '0;
		cur = 1'b0;
		e_thr = 8'h20 | 8'($random(seed));
		q_thr = 8'h7f & 8'($random(seed));
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		// ----
		// Registers, pin pairs, manual toggle
		// ----
		rchk(8'h00, 32'h0);
		rchk(8'h08, 32'h0);
		rchk(8'h10, 32'h0);
		wreg(8'h04, {16'h0, q_thr, e_thr});
		rchk(8'h04, {16'h0, q_thr, e_thr});
		for (int k = 0; k < 4; k++) begin
			wreg(8'h00, 32'(k) << 2);
			#1 chk({ant_alt, ant_def}, {exp_ant(k == 3, cur), exp_ant(k == 1, cur)}, "ant");
			chk({antenna_select_pin_a_oe_n, alt_antenna_select_pin_a_oe_n}, {k != 1, k != 3}, "oe");
		end
		wreg(8'h0c, 32'h1);
		cur = ~cur;
		@(posedge ref_clk);
		#1 chk({antenna_select_pin_a, antenna_select_pin_b}, {~cur, cur}, "manual");
		// ----
		// Transmit retries, then receive switching
		// ----
		wreg(8'h00, 32'h5);
		pulse(0);
		pulse(1);
		#1 chk(rx_mode, 1'b1, "rx_mode");
		rchk(8'h08, {30'h0, cur, cur});
		repeat (4) @(posedge ref_clk);
		for (int i = 0; i < 3; i++) begin
			pulse(3);
			pulse(4);
			cur = ~cur;
			#1 chk({antenna_select_pin_a, antenna_select_pin_b}, {~cur, cur}, "retry");
			pulse(1);
		end
		lt = cur;
		pulse(2);
		#1 chk(rx_mode, 1'b0, "ack");
		wreg(8'h00, 32'h4);
		pulse(0);
		pulse(1);
		pulse(3);
		pulse(4);
		#1 chk({antenna_select_pin_a, antenna_select_pin_b}, {~cur, cur}, "tx off");
		pulse(1);
		pulse(2);
		energy <= e_thr - 8'h1 - (8'($random(seed)) & 8'h1f);
		wreg(8'h00, 32'h6);
		wait_flip(n);
		cur = ~cur;
		wait_flip(n);
		cur = ~cur;
		chk(n, 1000, "interval");
		energy <= e_thr;
		wait_flip(n);
		chk(n, W, "energy at thr");
		energy <= 8'h0;
		rx_busy <= 1'b1;
		wait_flip(n);
		chk(n, W, "rx busy");
		preamble_quality <= q_thr + 8'h1;
		pulse(6);
		rx_busy <= 1'b0;
		p = antenna_select_pin_a;
		repeat (4) begin
			pulse(6);
			repeat (298) @(posedge ref_clk);
		end
		chk(antenna_select_pin_a, p, "preamble");
		preamble_quality <= q_thr;
		pulse(6);
		wait_flip(n);
		cur = ~cur;
		chk(n < W, 1'b1, "quality at thr");
		wreg(8'h00, 32'h4);
		pulse(5);
		rchk(8'h08, {29'h0, cur, lt, cur});
		tally_and_finish;
	end
endmodule
